// [hdl/lcc_pkg.sv]
// Shared constants and types for the display configuration command decoder
package lcc_pkg;
  // Command bytes, all sent with the select line low
  localparam logic [7:0] CMD_SUB_ENTER = 8'h70;
  localparam logic [7:0] CMD_SUB_EXIT = 8'h71;
  localparam logic [7:0] CMD_CONTRAST_SET = 8'h81;
  localparam logic [7:0] CMD_CONTRAST_GO = 8'hA0;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;
  localparam logic [7:0] CMD_RMW_ON = 8'hE0;
  localparam logic [7:0] CMD_RMW_END = 8'hE1;
  localparam logic [7:0] CMD_SUPPLY_BASE = 8'h20;
  localparam logic [7:0] CMD_BOOST_BASE = 8'h28;
  localparam logic [7:0] CMD_BIAS_BASE = 8'hB0;
  localparam logic [7:0] CMD_INV_BASE = 8'h60;
  // Opcode fields and their positions
  localparam logic [3:0] OPC_BIAS = 4'hB;
  localparam logic [3:0] OPC_INV = 4'h6;
  localparam logic [4:0] OPC_BOOST = 5'h05;
  localparam logic [6:0] OPC_SUPPLY = 7'h10;
  localparam logic [6:0] OPC_RMW = 7'h70;
  localparam int BIAS_TOP_BIT = 3;
  localparam int BOOST_TOP_BIT = 2;
  // Reset values
  localparam logic [7:0] CONTRAST_RST = 8'hFF;
  localparam logic [5:0] INV_RST = 6'h00;
  localparam logic [3:0] BIAS_RST = 4'h8;
  localparam logic [2:0] BOOST_RST = 3'h4;
  localparam logic [7:0] COL_RST = 8'h00;
  // Host hardware reset pulse
  localparam int CLK_PERIOD_NS = 10;
  localparam int HW_RST_TIME_NS = 1000;
  localparam int HW_RST_CYC = (HW_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_MAX = 5;

  typedef enum logic [2:0] {
    TBL_MAIN = 3'b001,
    TBL_SUB = 3'b010,
    TBL_SUB_EVR = 3'b100
  } lcc_tbl_e;

  typedef enum logic [3:0] {
    H_RST = 4'b0001,
    H_IDLE = 4'b0010,
    H_SEND = 4'b0100,
    H_GAP = 4'b1000
  } lcc_hst_e;

  typedef enum logic [3:0] {
    OP_INV = 4'h0,
    OP_CONTRAST = 4'h1,
    OP_BIAS = 4'h2,
    OP_BOOST = 4'h3,
    OP_SUPPLY = 4'h4,
    OP_RMW = 4'h5,
    OP_RMW_END = 4'h6,
    OP_SOFT_RST = 4'h7,
    OP_WR_DATA = 4'h8,
    OP_RD_DATA = 4'h9,
    OP_RAW = 4'hA
  } lcc_op_e;
endpackage

// [hdl/lcc_if.sv]
// Host to driver write port: strobes, select line, data byte and reset pin
`timescale 1ns/1ps
interface lcc_if;
  logic hardware_reset_pin_n;
  logic wr_stb;
  logic rd_stb;
  logic a0;
  logic [7:0] data;

  modport dev (
    input hardware_reset_pin_n,
    input wr_stb,
    input rd_stb,
    input a0,
    input data
  );

  modport host (
    output hardware_reset_pin_n,
    output wr_stb,
    output rd_stb,
    output a0,
    output data
  );
endinterface

// [hdl/lcc_col_ctr.sv]
// Column address counter with read-modify-write save and restore
`timescale 1ns/1ps
module lcc_col_ctr
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control pulses
  input wire logic clear,
  input wire logic wr_pulse,
  input wire logic rd_pulse,
  input wire logic rmw_on,
  input wire logic rmw_off,
  // State
  output logic [7:0] col,
  output logic rmw_active
);
  logic [7:0] saved;
  logic [7:0] next_col;
  logic [7:0] next_saved;
  logic next_rmw_active;

  always_comb begin
    next_col = col;
    next_saved = saved;
    next_rmw_active = rmw_active;
    if (clear) begin
      next_col = COL_RST;
      next_rmw_active = 1'b0;
    end else if (rmw_on) begin
      next_saved = col;
      next_rmw_active = 1'b1;
    end else if (rmw_off) begin
      // End outside the mode would jump to a stale address
      if (rmw_active) begin
        next_col = saved;
      end
      next_rmw_active = 1'b0;
    end else if (wr_pulse) begin
      next_col = col + 8'h01;
    end else if (rd_pulse && !rmw_active) begin
      next_col = col + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      col <= 8'h00;
      saved <= 8'h00;
      rmw_active <= 1'b0;
    end else begin
      col <= next_col;
      saved <= next_saved;
      rmw_active <= next_rmw_active;
    end
  end
endmodule

// [hdl/lcc_dev.sv]
// Driver end: decodes host command bytes into display configuration state
// Function
// - Six-bit count sets line inversion period
// - Host sends inversion bytes in sub table
// - Eight-bit contrast level, 201 usable steps
// - Contrast applies only after trigger byte A0
// - Host writes all ones when contrast unused
// - Byte 71 returns decoding to main table
// - Host sends no main commands in sub
// - Bias nibble selects 1/4 to 1/12
// - Three-bit field selects booster multiple
// - Host limits booster to fitted capacitors
// - Read-modify-write: writes step column, reads not
// - End restores column saved at entry
// - Host avoids column set during read-modify-write
// - Soft reset loads documented default settings
// - Soft reset leaves display memory untouched
// - Host pulses hardware reset at power-on
// - Supply command bit switches internal supply
// - Booster runs only with oscillator running
// - Host keeps supply off with external supply
// - Byte 70 selects the sub table
`timescale 1ns/1ps
module lcc_dev
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host link
  lcc_if.dev link,
  // Display timing inputs
  input wire logic osc_running,
  input wire logic line_tick,
  // Configuration state
  output logic [7:0] contrast_level_register,
  output logic [5:0] line_inversion_count,
  output logic [3:0] bias_sel,
  output logic [2:0] boost_sel,
  output logic supply_on,
  output logic booster_run,
  output logic full_display,
  output logic sub_table_active,
  // Line drive
  output logic drive_polarity,
  // Column addressing
  output logic [7:0] column_addr,
  output logic rmw_active,
  output logic soft_reset_pulse
);
  lcc_tbl_e tbl;
  lcc_tbl_e next_tbl;
  logic [7:0] contrast_pend;
  logic [5:0] inv_pend;
  logic inv_hi;
  logic [7:0] next_contrast;
  logic [7:0] next_contrast_pend;
  logic [5:0] next_inv;
  logic [5:0] next_inv_pend;
  logic next_inv_hi;
  logic [3:0] next_bias;
  logic [2:0] next_boost;
  logic next_supply;
  logic next_full;
  logic next_soft_rst;
  logic col_clear;
  logic rmw_on;
  logic rmw_off;
  logic cmd_stb;
  logic [7:0] d;
  logic osc_meta;
  logic osc_sync;
  logic next_booster_run;
  logic [5:0] line_cnt;
  logic [5:0] next_line_cnt;
  logic next_pol;
  logic [7:0] col_q;
  logic rmw_q;

  // Bias field: any value with the top bit set is the widest ratio
  function automatic logic [3:0] bias_decode(input logic [3:0] f);
    bias_decode = f[BIAS_TOP_BIT] ? BIAS_RST : f;
  endfunction

  // Booster field: 1xx collapses to the highest multiple
  function automatic logic [2:0] boost_decode(input logic [2:0] f);
    boost_decode = f[BOOST_TOP_BIT] ? BOOST_RST : f;
  endfunction

  assign cmd_stb = link.wr_stb && !link.a0;
  assign d = link.data;

  always_comb begin
    next_tbl = tbl;
    next_contrast = contrast_level_register;
    next_contrast_pend = contrast_pend;
    next_inv = line_inversion_count;
    next_inv_pend = inv_pend;
    next_inv_hi = inv_hi;
    next_bias = bias_sel;
    next_boost = boost_sel;
    next_supply = supply_on;
    next_full = full_display;
    next_soft_rst = 1'b0;
    col_clear = 1'b0;
    rmw_on = 1'b0;
    rmw_off = 1'b0;
    if (!link.hardware_reset_pin_n) begin
      next_tbl = TBL_MAIN;
      next_contrast = CONTRAST_RST;
      next_contrast_pend = CONTRAST_RST;
      next_inv = INV_RST;
      next_inv_pend = INV_RST;
      next_inv_hi = 1'b1;
      next_bias = BIAS_RST;
      next_boost = BOOST_RST;
      next_supply = 1'b0;
      next_full = 1'b1;
      col_clear = 1'b1;
    end else if (cmd_stb) begin
      case (tbl)
        TBL_MAIN: begin
          if (d == CMD_SUB_ENTER) begin
            next_tbl = TBL_SUB;
            next_inv_hi = 1'b1;
          end else if (d == CMD_SOFT_RESET) begin
            // Display memory lives outside; nothing here touches it
            next_tbl = TBL_MAIN;
            next_contrast = CONTRAST_RST;
            next_contrast_pend = CONTRAST_RST;
            next_inv = INV_RST;
            next_inv_pend = INV_RST;
            next_bias = BIAS_RST;
            next_boost = BOOST_RST;
            next_full = 1'b1;
            next_soft_rst = 1'b1;
            col_clear = 1'b1;
          end else if (d[7:4] == OPC_BIAS) begin
            next_bias = bias_decode(d[3:0]);
          end else if (d[7:3] == OPC_BOOST) begin
            next_boost = boost_decode(d[2:0]);
          end else if (d[7:1] == OPC_SUPPLY) begin
            next_supply = d[0];
          end else if (d[7:1] == OPC_RMW) begin
            rmw_on = !d[0];
            rmw_off = d[0];
          end
        end
        TBL_SUB: begin
          if (d == CMD_SUB_EXIT) begin
            next_tbl = TBL_MAIN;
          end else if (d == CMD_SUB_ENTER) begin
            // Repeated sub-table byte is the inversion trigger
            next_inv = inv_pend;
            next_inv_hi = 1'b1;
          end else if (d == CMD_CONTRAST_GO) begin
            next_contrast = contrast_pend;
          end else if (d == CMD_CONTRAST_SET) begin
            next_tbl = TBL_SUB_EVR;
          end else if (d[7:4] == OPC_INV) begin
            if (inv_hi) begin
              next_inv_pend = {d[1:0], inv_pend[3:0]};
            end else begin
              next_inv_pend = {inv_pend[5:4], d[3:0]};
            end
            next_inv_hi = !inv_hi;
          end
        end
        TBL_SUB_EVR: begin
          next_contrast_pend = d;
          next_tbl = TBL_SUB;
        end
        default: begin
          next_tbl = TBL_MAIN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tbl <= TBL_MAIN;
      contrast_level_register <= 8'hFF;
      contrast_pend <= 8'hFF;
      line_inversion_count <= 6'h00;
      inv_pend <= 6'h00;
      inv_hi <= 1'b1;
      bias_sel <= 4'h8;
      boost_sel <= 3'h4;
      supply_on <= 1'b0;
      full_display <= 1'b1;
      soft_reset_pulse <= 1'b0;
      sub_table_active <= 1'b0;
    end else begin
      tbl <= next_tbl;
      contrast_level_register <= next_contrast;
      contrast_pend <= next_contrast_pend;
      line_inversion_count <= next_inv;
      inv_pend <= next_inv_pend;
      inv_hi <= next_inv_hi;
      bias_sel <= next_bias;
      boost_sel <= next_boost;
      supply_on <= next_supply;
      full_display <= next_full;
      soft_reset_pulse <= next_soft_rst;
      sub_table_active <= (next_tbl != TBL_MAIN);
    end
  end

  // Oscillator status comes from the analog side, so it is synchronised
  always_comb begin
    next_booster_run = supply_on && osc_sync;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      booster_run <= 1'b0;
    end else begin
      osc_meta <= osc_running;
      osc_sync <= osc_meta;
      booster_run <= next_booster_run;
    end
  end

  // Polarity flips after every count+1 lines; a zero count holds it low
  always_comb begin
    next_line_cnt = line_cnt;
    next_pol = drive_polarity;
    if (line_inversion_count == 6'h00) begin
      next_line_cnt = 6'h00;
      next_pol = 1'b0;
    end else if (line_tick) begin
      if (line_cnt >= line_inversion_count) begin
        next_line_cnt = 6'h00;
        next_pol = !drive_polarity;
      end else begin
        next_line_cnt = line_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_cnt <= 6'h00;
      drive_polarity <= 1'b0;
    end else begin
      line_cnt <= next_line_cnt;
      drive_polarity <= next_pol;
    end
  end

  lcc_col_ctr u_col (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(col_clear),
    .wr_pulse(link.wr_stb && link.a0),
    .rd_pulse(link.rd_stb && link.a0),
    .rmw_on(rmw_on),
    .rmw_off(rmw_off),
    .col(col_q),
    .rmw_active(rmw_q)
  );

  // Column state is re-registered so every output leaves a flop here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      column_addr <= 8'h00;
      rmw_active <= 1'b0;
    end else begin
      column_addr <= col_q;
      rmw_active <= rmw_q;
    end
  end
endmodule

// [hdl/lcc_host.sv]
// Host end: turns configuration requests into ordered command byte strobes
`timescale 1ns/1ps
module lcc_host
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Driver link
  lcc_if.host link,
  // Request port
  input wire logic op_valid,
  input wire lcc_op_e op_code,
  input wire logic [7:0] op_arg,
  output logic op_ready,
  // System options
  input wire logic use_contrast,
  input wire logic ext_supply,
  input wire logic [2:0] boost_max
);
  lcc_hst_e st;
  lcc_hst_e next_st;
  lcc_op_e op_q;
  lcc_op_e next_op;
  logic [7:0] arg_q;
  logic [7:0] next_arg;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;
  logic rmw_on;
  logic next_rmw_on;
  logic next_ready;
  logic next_rst_n;
  logic next_wr;
  logic next_rd;
  logic next_a0;
  logic [7:0] next_data;
  logic [10:0] step;

  // Returns {last, rd, a0, byte} for step i of a request
  function automatic logic [10:0] seq_step(input lcc_op_e op, input logic [7:0] a, input logic [2:0] i,
                                            input logic use_c, input logic ext, input logic [2:0] bmax);
    logic [7:0] b;
    logic [7:0] v;
    logic last;
    b = CMD_SUB_ENTER;
    v = use_c ? a : CONTRAST_RST;
    last = 1'b1;
    seq_step = 11'h000;
    case (op)
      OP_INV: begin
        // Sub-table bracket keeps main commands out of sub mode
        case (i)
          3'd0: b = CMD_SUB_ENTER;
          3'd1: b = CMD_INV_BASE | {6'h00, a[5:4]};
          3'd2: b = CMD_INV_BASE | {4'h0, a[3:0]};
          3'd3: b = CMD_SUB_ENTER;
          default: b = CMD_SUB_EXIT;
        endcase
        last = (i == 3'd4);
        seq_step = {last, 2'b00, b};
      end
      OP_CONTRAST: begin
        case (i)
          3'd0: b = CMD_SUB_ENTER;
          3'd1: b = CMD_CONTRAST_SET;
          3'd2: b = v;
          3'd3: b = CMD_CONTRAST_GO;
          default: b = CMD_SUB_EXIT;
        endcase
        last = (i == 3'd4);
        seq_step = {last, 2'b00, b};
      end
      OP_BIAS: seq_step = {3'b100, CMD_BIAS_BASE | {4'h0, a[3:0]}};
      OP_BOOST: seq_step = {3'b100, CMD_BOOST_BASE | {5'h00, (a[2:0] > bmax) ? bmax : a[2:0]}};
      OP_SUPPLY: seq_step = {3'b100, CMD_SUPPLY_BASE | {7'h00, a[0] && !ext}};
      OP_RMW: seq_step = {3'b100, CMD_RMW_ON};
      OP_RMW_END: seq_step = {3'b100, CMD_RMW_END};
      OP_SOFT_RST: seq_step = {3'b100, CMD_SOFT_RESET};
      OP_WR_DATA: seq_step = {3'b101, a};
      OP_RD_DATA: seq_step = {3'b111, 8'h00};
      OP_RAW: seq_step = {3'b100, a};
      default: seq_step = {3'b100, CMD_SUB_EXIT};
    endcase
  endfunction

  assign step = seq_step(op_q, arg_q, idx, use_contrast, ext_supply, boost_max);

  always_comb begin
    next_st = st;
    next_op = op_q;
    next_arg = arg_q;
    next_idx = idx;
    next_rst_cnt = rst_cnt;
    next_rmw_on = rmw_on;
    next_rst_n = 1'b1;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_a0 = link.a0;
    next_data = link.data;
    case (st)
      H_RST: begin
        next_rst_n = 1'b0;
        next_rmw_on = 1'b0;
        if (rst_cnt == 8'(HW_RST_CYC - 1)) begin
          next_rst_n = 1'b1;
          next_st = H_IDLE;
        end else begin
          next_rst_cnt = rst_cnt + 8'h01;
        end
      end
      H_IDLE: begin
        // Raw bytes could carry a column set, so they are dropped during the mode while op_ready stays high
        if (op_valid && !(op_code == OP_RAW && rmw_on)) begin
          next_op = op_code;
          next_arg = op_arg;
          next_idx = 3'd0;
          next_st = H_SEND;
        end
      end
      H_SEND: begin
        next_wr = !step[9];
        next_rd = step[9];
        next_a0 = step[8];
        next_data = step[7:0];
        if (op_q == OP_RMW) begin
          next_rmw_on = 1'b1;
        end else if (op_q == OP_RMW_END || op_q == OP_SOFT_RST) begin
          next_rmw_on = 1'b0;
        end
        next_st = H_GAP;
      end
      H_GAP: begin
        if (step[10]) begin
          next_st = H_IDLE;
        end else begin
          next_idx = idx + 3'd1;
          next_st = H_SEND;
        end
      end
      default: begin
        next_st = H_IDLE;
      end
    endcase
    next_ready = (next_st == H_IDLE);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= H_RST;
      op_q <= OP_RAW;
      arg_q <= 8'h00;
      idx <= 3'd0;
      rst_cnt <= 8'h00;
      rmw_on <= 1'b0;
      op_ready <= 1'b0;
      link.hardware_reset_pin_n <= 1'b0;
      link.wr_stb <= 1'b0;
      link.rd_stb <= 1'b0;
      link.a0 <= 1'b0;
      link.data <= 8'h00;
    end else begin
      st <= next_st;
      op_q <= next_op;
      arg_q <= next_arg;
      idx <= next_idx;
      rst_cnt <= next_rst_cnt;
      rmw_on <= next_rmw_on;
      op_ready <= next_ready;
      link.hardware_reset_pin_n <= next_rst_n;
      link.wr_stb <= next_wr;
      link.rd_stb <= next_rd;
      link.a0 <= next_a0;
      link.data <= next_data;
    end
  end
endmodule

// [tb/lcc_chk.sv]
// Link protocol and decode checks beside the host to driver interface
`timescale 1ns/1ps
module lcc_chk
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link
  input wire logic hardware_reset_pin_n,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic a0,
  input wire logic [7:0] data,
  // Driver state
  input wire logic sub_table_active,
  input wire logic [3:0] bias_sel,
  input wire logic [2:0] boost_sel,
  input wire logic supply_on,
  input wire logic booster_run
);
  logic cmd;
  logic after_set;
  logic next_after_set;
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;

  assign cmd = wr_stb && !a0;

  // A byte after the contrast opcode is a value, not a command
  always_comb begin
    next_after_set = wr_stb ? (cmd && sub_table_active && !after_set && data == CMD_CONTRAST_SET) : after_set;
    next_low_cnt = (!hardware_reset_pin_n && low_cnt != 8'hFF) ? low_cnt + 8'h01 : low_cnt;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      after_set <= 1'b0;
      low_cnt <= 8'h00;
    end else begin
      after_set <= next_after_set;
      low_cnt <= next_low_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rst_pin;
    $rose(hardware_reset_pin_n) |-> low_cnt >= 8'h63 && low_cnt <= 8'h65;
  endproperty
  property p_sub_enter;
    cmd && !after_set && data == CMD_SUB_ENTER |=> sub_table_active;
  endproperty
  property p_sub_exit;
    cmd && !after_set && data == CMD_SUB_EXIT |=> !sub_table_active;
  endproperty
  property p_bias;
    cmd && !sub_table_active && data[7:4] == OPC_BIAS |=>
      bias_sel == ($past(data[3]) ? 4'h8 : {1'b0, $past(data[2:0])});
  endproperty
  property p_boost;
    cmd && !sub_table_active && data[7:3] == OPC_BOOST |=>
      boost_sel == ($past(data[2]) ? 3'h4 : $past(data[2:0]));
  endproperty
  property p_no_main;
    cmd && sub_table_active && !after_set |-> data == CMD_SUB_ENTER || data == CMD_SUB_EXIT ||
      data == CMD_CONTRAST_GO || data == CMD_CONTRAST_SET || data[7:4] == OPC_INV;
  endproperty
  property p_contrast;
    cmd && sub_table_active && !after_set && data == CMD_CONTRAST_SET |->
      ##2 cmd ##2 (cmd && data == CMD_CONTRAST_GO);
  endproperty
  property p_booster;
    !supply_on [*2] |-> !booster_run;
  endproperty

  a_rst_pin: assert property (p_rst_pin) else $error("reset pin released after wrong span");
  a_sub_enter: assert property (p_sub_enter) else $error("sub table not selected");
  a_sub_exit: assert property (p_sub_exit) else $error("sub table not left");
  a_bias: assert property (p_bias) else $error("bias select wrong");
  a_boost: assert property (p_boost) else $error("booster multiple wrong");
  a_no_main: assert property (p_no_main) else $error("main command sent in sub table");
  a_contrast: assert property (p_contrast) else $error("contrast trigger missing");
  a_booster: assert property (p_booster) else $error("booster runs with supply off");

  c_sub: cover property (cmd && data == CMD_SUB_ENTER);
  c_go: cover property (cmd && data == CMD_CONTRAST_GO);
  c_bias: cover property (cmd && data[7:4] == OPC_BIAS);
endmodule

// [tb/testbench.sv]
// Bench: host end drives driver end; a raw link drives a second driver end out of order
`timescale 1ns/1ps
module testbench;
  import lcc_pkg::*;
  logic clk, sys_rst, op_valid, op_ready, use_contrast, ext_supply, osc_running, line_tick, p, srp_seen;
  lcc_op_e op_code;
  logic [7:0] op_arg, contrast_level_register, column_addr, c2, v, c0;
  logic [5:0] line_inversion_count;
  logic [3:0] bias_sel, b2;
  logic [2:0] boost_sel, boost_max;
  logic supply_on, booster_run, full_display, sub_table_active, drive_polarity, rmw_active, soft_reset_pulse, s2;
  logic [7:0] ks[5];
  int num_errors = 0;
  int tests_run = 0;
  int i, j;
  lcc_if link ();
  lcc_if raw ();

  lcc_host u_lcc_host (.clk(clk), .sys_rst(sys_rst), .link(link.host), .op_valid(op_valid), .op_code(op_code),
    .op_arg(op_arg), .op_ready(op_ready), .use_contrast(use_contrast), .ext_supply(ext_supply),
    .boost_max(boost_max));
  lcc_dev u_lcc_dev (.clk(clk), .sys_rst(sys_rst), .link(link.dev), .osc_running(osc_running),
    .line_tick(line_tick), .contrast_level_register(contrast_level_register),
    .line_inversion_count(line_inversion_count), .bias_sel(bias_sel), .boost_sel(boost_sel), .supply_on(supply_on),
    .booster_run(booster_run), .full_display(full_display), .sub_table_active(sub_table_active),
    .drive_polarity(drive_polarity), .column_addr(column_addr), .rmw_active(rmw_active),
    .soft_reset_pulse(soft_reset_pulse));
  lcc_dev u_lcc_dev_raw (.clk(clk), .sys_rst(sys_rst), .link(raw.dev), .osc_running(osc_running),
    .line_tick(line_tick), .contrast_level_register(c2), .line_inversion_count(), .bias_sel(b2), .boost_sel(),
    .supply_on(), .booster_run(), .full_display(), .sub_table_active(s2), .drive_polarity(), .column_addr(),
    .rmw_active(), .soft_reset_pulse());
  lcc_chk u_lcc_chk (.clk(clk), .sys_rst(sys_rst), .hardware_reset_pin_n(link.hardware_reset_pin_n),
    .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .a0(link.a0), .data(link.data),
    .sub_table_active(sub_table_active), .bias_sel(bias_sel), .boost_sel(boost_sel), .supply_on(supply_on),
    .booster_run(booster_run));

  function automatic logic [7:0] exp_bias(input logic [3:0] f);
    return f[3] ? 8'h08 : {5'h00, f[2:0]};
  endfunction
  function automatic logic [7:0] exp_boost(input logic [2:0] f);
    return f[2] ? 8'h04 : {5'h00, f};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) chk("op_ready", {7'h00, op_ready}, 8'h01);
  endtask

  // Column lags the strobe by two cycles, so settle before returning
  task automatic req(input lcc_op_e op, input logic [7:0] arg);
    wait_rdy();
    op_valid = 1'b1;
    op_code = op;
    op_arg = arg;
    @(negedge clk);
    op_valid = 1'b0;
    @(negedge clk);
    wait_rdy();
    repeat (2) @(negedge clk);
  endtask

  // Raw driver scrambles the data bus once the strobe is gone
  task automatic raw_wr(input logic [7:0] b);
    raw.wr_stb = 1'b1;
    raw.data = b;
    @(negedge clk);
    raw.wr_stb = 1'b0;
    raw.data = ~b;
    @(negedge clk);
  endtask

  task automatic tick;
    line_tick = 1'b1;
    @(negedge clk);
    line_tick = 1'b0;
    @(negedge clk);
  endtask

  always @(posedge clk) if (soft_reset_pulse === 1'b1) srp_seen <= 1'b1;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #500000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    sys_rst = 1'b1;
    {op_valid, line_tick, osc_running, ext_supply, srp_seen} = 5'h00;
    op_code = OP_RAW;
    op_arg = 8'h00;
    use_contrast = 1'b1;
    boost_max = 3'h7;
    {raw.hardware_reset_pin_n, raw.wr_stb, raw.rd_stb, raw.a0, raw.data} = 12'h000;
    void'($urandom(32'h6738));
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    raw.hardware_reset_pin_n = 1'b1;
    wait_rdy();
    chk("contrast", contrast_level_register, 8'hFF);
    chk("bias", {4'h0, bias_sel}, 8'h08);
    chk("boost", {5'h00, boost_sel}, 8'h04);
    chk("sub", {7'h00, sub_table_active}, 8'h00);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      req(OP_BIAS, 8'(i));
      chk("bias", {4'h0, bias_sel}, exp_bias(4'(i)));
    end
    $display("test bias done");
    for (i = 0; i < 14; i++) begin
      boost_max = (i < 8) ? 3'h7 : 3'($urandom % 8);
      v = (i < 8) ? 8'(i) : 8'($urandom % 8);
      req(OP_BOOST, v);
      chk("boost", {5'h00, boost_sel}, exp_boost((v[2:0] < boost_max) ? v[2:0] : boost_max));
    end
    boost_max = 3'h7;
    $display("test boost done");
    for (i = 0; i < 5; i++) begin
      use_contrast = (i != 4);
      v = (i == 0) ? 8'h37 : (i == 1) ? 8'hFF : 8'($urandom);
      req(OP_CONTRAST, v);
      chk("contrast", contrast_level_register, use_contrast ? v : 8'hFF);
      chk("sub", {7'h00, sub_table_active}, 8'h00);
    end
    use_contrast = 1'b1;
    $display("test contrast done");
    ks = '{8'h01, 8'h02, 8'h3F, 8'h00, 8'h01 + 8'($urandom % 62)};
    foreach (ks[n]) begin
      req(OP_INV, ks[n]);
      chk("inv_count", {2'h0, line_inversion_count}, ks[n]);
      if (ks[n] == 8'h00) begin
        repeat (3) tick();
        chk("pol_off", {7'h00, drive_polarity}, 8'h00);
      end else begin
        p = drive_polarity;
        for (j = 0; j < 70 && drive_polarity === p; j++) tick();
        for (j = 0; j <= int'(ks[n]); j++) begin
          p = drive_polarity;
          tick();
          chk("pol", {7'h00, drive_polarity}, {7'h00, (j == int'(ks[n])) ? ~p : p});
        end
      end
    end
    $display("test inversion done");
    osc_running = 1'b1;
    req(OP_SUPPLY, 8'h01);
    repeat (4) @(negedge clk);
    chk("supply", {7'h00, supply_on}, 8'h01);
    chk("booster", {7'h00, booster_run}, 8'h01);
    osc_running = 1'b0;
    repeat (4) @(negedge clk);
    chk("booster", {7'h00, booster_run}, 8'h00);
    req(OP_SUPPLY, 8'h00);
    chk("supply", {7'h00, supply_on}, 8'h00);
    ext_supply = 1'b1;
    req(OP_SUPPLY, 8'h01);
    chk("supply", {7'h00, supply_on}, 8'h00);
    ext_supply = 1'b0;
    $display("test supply done");
    req(OP_WR_DATA, 8'($urandom));
    c0 = column_addr;
    req(OP_RMW, 8'h00);
    chk("rmw", {7'h00, rmw_active}, 8'h01);
    req(OP_RAW, 8'hB5);
    chk("bias", {4'h0, bias_sel}, 8'h08);
    repeat (3) req(OP_WR_DATA, 8'($urandom));
    repeat (2) req(OP_RD_DATA, 8'h00);
    chk("col", column_addr, c0 + 8'h03);
    req(OP_RMW_END, 8'h00);
    chk("col", column_addr, c0);
    chk("rmw", {7'h00, rmw_active}, 8'h00);
    req(OP_RAW, 8'hB5);
    chk("bias", {4'h0, bias_sel}, 8'h05);
    $display("test rmw done");
    req(OP_BIAS, 8'h02);
    req(OP_CONTRAST, 8'h40);
    req(OP_INV, 8'h05);
    req(OP_BOOST, 8'h01);
    req(OP_SOFT_RST, 8'h00);
    chk("contrast", contrast_level_register, 8'hFF);
    chk("inv_count", {2'h0, line_inversion_count}, 8'h00);
    chk("bias", {4'h0, bias_sel}, 8'h08);
    chk("boost", {5'h00, boost_sel}, 8'h04);
    chk("col", column_addr, 8'h00);
    chk("full", {7'h00, full_display}, 8'h01);
    chk("srp", {7'h00, srp_seen}, 8'h01);
    $display("test soft reset done");
    raw_wr(CMD_SUB_ENTER);
    chk("raw_sub", {7'h00, s2}, 8'h01);
    raw_wr(8'hB3);
    chk("raw_bias", {4'h0, b2}, 8'h08);
    raw_wr(CMD_CONTRAST_SET);
    raw_wr(8'h55);
    raw_wr(CMD_SUB_EXIT);
    chk("raw_contrast", c2, 8'hFF);
    chk("raw_sub", {7'h00, s2}, 8'h00);
    raw_wr(8'hB3);
    chk("raw_bias", {4'h0, b2}, 8'h03);
    raw_wr(CMD_SUB_ENTER);
    raw.hardware_reset_pin_n = 1'b0;
    @(negedge clk);
    raw.hardware_reset_pin_n = 1'b1;
    @(negedge clk);
    chk("raw_sub", {7'h00, s2}, 8'h00);
    chk("raw_bias", {4'h0, b2}, 8'h08);
    $display("test raw link done");
    tally_and_finish();
  end
endmodule
